/* common_status_pkg.sv */
package common_status_pkg;

  // ==========================================================
  // Commands and carriers
  typedef enum logic [2:0] {
    CMD_SERVICE_REQUEST_MASK = 3'h0,
    CMD_MASK_QUERY = 3'h1,
    CMD_STATUS_SUMMARY_QUERY = 3'h2,
    CMD_HOST_BUS_TRIGGER = 3'h3,
    CMD_SELF_CHECK_QUERY = 3'h4,
    CMD_HOLD_UNTIL_DONE = 3'h5
  } cmd_code_t;

  typedef struct packed {
    cmd_code_t code;
    logic [15:0] arg;
  } cmd_req_t;

  typedef struct packed {
    logic fail;
    logic [8:0] id;
    logic chan_valid;
    logic [5:0] chan;
    logic range_valid;
    logic [2:0] range;
  } test_result_t;

  typedef enum logic [1:0] {
    ENTRY_TEST = 2'h0,
    ENTRY_CHAN = 2'h1,
    ENTRY_RANGE = 2'h2
  } entry_kind_t;

  // ==========================================================
  // Status byte layout
  localparam int BIT_OPER = 7;
  localparam int BIT_RQS = 6;
  localparam int BIT_STD = 5;
  localparam int BIT_MAV = 4;
  localparam int BIT_QUES = 3;
  localparam logic [7:0] MASK_WRITABLE = 8'hb8;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ==========================================================
  // Self check codes
  localparam logic [15:0] REPLY_PASS = 16'h0000;
  localparam logic [15:0] REPLY_FAIL = 16'hffff;
  localparam logic [15:0] ERR_SELF_CHECK = 16'h0bec;
  localparam logic [15:0] TEST_LOW_MIN = 16'h0001;
  localparam logic [15:0] TEST_LOW_MAX = 16'h0063;
  localparam logic [15:0] TEST_HIGH_MIN = 16'h012c;
  localparam logic [15:0] CHAN_BASE = 16'h0064;
  localparam logic [15:0] CHAN_MAX = 16'h00a3;
  localparam logic [15:0] RANGE_BASE = 16'h00c8;
  localparam logic [15:0] RANGE_MAX = 16'h00cc;
  localparam logic [2:0] RANGE_LAST = 3'h4;
  localparam logic [8:0] TEST_FIRST = 9'h001;
  localparam logic [8:0] TEST_A24_LO = 9'h002;
  localparam logic [8:0] TEST_A24_HI = 9'h003;
  localparam logic [8:0] TEST_MEAS = 9'h006;
  localparam logic [8:0] TEST_FIFO_IRQ = 9'h007;
  localparam logic [8:0] TEST_LAST_DIGITAL = 9'h009;
  localparam logic [8:0] TEST_REST_GROUP = 9'h000;

endpackage

/* fail_code_encoder.sv */
`timescale 1ns/1ps
module fail_code_encoder
  import common_status_pkg::*;
(
  // Entry selection
  input wire entry_kind_t kind_i,
  input wire logic [8:0] value_i,
  // Encoded entry
  output logic [15:0] code_o,
  output logic ok_o
);

  always_comb
  begin
    code_o = {7'h00, value_i};
    ok_o = 1'b0;
    case (kind_i)
      ENTRY_TEST:
      begin
        code_o = {7'h00, value_i};
        ok_o = (code_o >= TEST_LOW_MIN && code_o <= TEST_LOW_MAX) || code_o >= TEST_HIGH_MIN;
      end
      ENTRY_CHAN:
      begin
        code_o = CHAN_BASE + {10'h000, value_i[5:0]};
        ok_o = 1'b1;
      end
      ENTRY_RANGE:
      begin
        code_o = RANGE_BASE + {13'h0000, value_i[2:0]};
        ok_o = value_i[2:0] <= RANGE_LAST;
      end
      default:
      begin
        code_o = {7'h00, value_i};
        ok_o = 1'b0;
      end
    endcase
  end

endmodule

/* service_request_logic.sv */
`timescale 1ns/1ps
module service_request_logic
  import common_status_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Event summaries
  input wire logic oper_i,
  input wire logic std_i,
  input wire logic mav_i,
  input wire logic ques_i,
  input wire logic [7:0] mask_i,
  // Status
  output logic [7:0] stb_o,
  output logic rqs_o,
  output logic enabled_any_o
);

  logic [7:0] summary;
  logic [7:0] enabled;
  logic [7:0] enabled_prev;
  logic rqs;

  // ==========================================================
  // Summary and request
  always_comb
  begin
    summary = BYTE_ZERO;
    summary[BIT_OPER] = oper_i;
    summary[BIT_STD] = std_i;
    summary[BIT_MAV] = mav_i;
    summary[BIT_QUES] = ques_i;
    enabled = summary & mask_i;
    stb_o = summary;
    stb_o[BIT_RQS] = rqs;
  end

  assign rqs_o = rqs;
  assign enabled_any_o = |enabled;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      enabled_prev <= BYTE_ZERO;
    else
      enabled_prev <= enabled;
  end

  // A new enabled event wins over the release in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rqs <= 1'b0;
    else if (|(enabled & ~enabled_prev))
      rqs <= 1'b1;
    else if (enabled == BYTE_ZERO)
      rqs <= 1'b0;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_MASKED_EVENT_SEEN: assert property (oper_i && !mask_i[BIT_OPER] |-> stb_o[BIT_OPER])
    else $error("masked event not shown in status byte");
  AST_NEW_EVENT_REQUEST: assert property ($rose(std_i) && mask_i[BIT_STD] |=> rqs_o)
    else $error("enabled event did not raise request");
  AST_UNUSED_BITS_ZERO: assert property (stb_o[2:0] == 3'h0)
    else $error("unused status bits set");
  AST_REQUEST_RELEASE: assert property (!enabled_any_o ##1 !enabled_any_o |-> !rqs_o)
    else $error("request held with nothing enabled");

  COV_REQUEST: cover property ($rose(rqs_o));
  COV_RELEASE: cover property ($fell(rqs_o));

endmodule

/* common_command_status_unit.sv */
`timescale 1ns/1ps
module common_command_status_unit
  import common_status_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Command port
  input wire logic CMD_VALID_I,
  input wire cmd_req_t CMD_I,
  output logic CMD_READY_O,
  // Output queue
  output logic RESP_VALID_O,
  output logic [15:0] RESP_DATA_O,
  input wire logic RESP_TAKEN_I,
  // Event summaries
  input wire logic OPER_SUM_I,
  input wire logic STD_SUM_I,
  input wire logic QUES_SUM_I,
  output logic [7:0] STATUS_BYTE_O,
  // Service request pin, open drain
  output logic SRQ_O,
  output logic SRQ_OE_O,
  // Trigger system
  input wire logic TRIG_SRC_BUS_I,
  input wire logic TRIG_WAITING_I,
  output logic TRIG_O,
  // Operation in progress
  input wire logic OP_BUSY_I,
  // Test engine
  output logic TEST_REQ_O,
  output logic [8:0] TEST_NUM_O,
  output logic TEST_A24_O,
  input wire logic TEST_DONE_I,
  input wire test_result_t TEST_RESULT_I,
  input wire logic FIFO_HALF_IRQ_I,
  input wire logic FIFO_FULL_IRQ_I,
  input wire logic MEAS_STAT_I,
  // Data FIFO and error queue
  output logic FIFO_WR_O,
  output logic [15:0] FIFO_DATA_O,
  output logic ERR_PUSH_O,
  output logic [15:0] ERR_CODE_O,
  output logic DEFAULTS_O
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ISSUE = 4'h1,
    ST_WAIT = 4'h3,
    ST_LOG_TEST = 4'h2,
    ST_LOG_CHAN = 4'h6,
    ST_LOG_RANGE = 4'h7,
    ST_NEXT = 4'h5,
    ST_ERR = 4'h4,
    ST_DEFAULTS = 4'hc,
    ST_REPLY = 4'hd
  } check_state_t;

  check_state_t st;
  check_state_t next_st;
  logic accept;
  logic [7:0] mask;
  logic [7:0] stb;
  logic rqs;
  logic enabled_any;
  logic holding;
  logic [8:0] test_num;
  logic [8:0] fail_id;
  test_result_t res;
  logic any_fail;
  logic step_fail;
  logic seen_half;
  logic seen_full;
  logic seen_meas;
  entry_kind_t enc_kind;
  logic [8:0] enc_value;
  logic [15:0] enc_code;
  logic enc_ok;

  assign accept = CMD_VALID_I && CMD_READY_O;

  // ==========================================================
  // Status byte and service request
  service_request_logic u_srq (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .oper_i(OPER_SUM_I),
    .std_i(STD_SUM_I),
    .mav_i(RESP_VALID_O),
    .ques_i(QUES_SUM_I),
    .mask_i(mask),
    .stb_o(stb),
    .rqs_o(rqs),
    .enabled_any_o(enabled_any)
  );

  // Request bit cannot itself be enabled
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      mask <= MASK_RESET;
    else if (accept && CMD_I.code == CMD_SERVICE_REQUEST_MASK)
      mask <= CMD_I.arg[7:0] & MASK_WRITABLE;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      SRQ_O <= 1'b0;
      SRQ_OE_O <= 1'b0;
      STATUS_BYTE_O <= BYTE_ZERO;
    end
    else
    begin
      SRQ_O <= 1'b0;
      SRQ_OE_O <= rqs;
      STATUS_BYTE_O <= stb;
    end
  end

  // ==========================================================
  // Command acceptance
  // Ready drops for a cycle after each accept so effects settle
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      CMD_READY_O <= 1'b0;
    else if (accept)
      CMD_READY_O <= 1'b0;
    else
      CMD_READY_O <= st == ST_IDLE && !RESP_VALID_O && !holding;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      holding <= 1'b0;
    else if (accept && CMD_I.code == CMD_HOLD_UNTIL_DONE)
      holding <= 1'b1;
    else if (!OP_BUSY_I)
      holding <= 1'b0;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      TRIG_O <= 1'b0;
    else
      TRIG_O <= accept && CMD_I.code == CMD_HOST_BUS_TRIGGER
                && TRIG_SRC_BUS_I && TRIG_WAITING_I;
  end

  // ==========================================================
  // Output queue, one entry
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      RESP_VALID_O <= 1'b0;
      RESP_DATA_O <= REPLY_PASS;
    end
    else if (accept && CMD_I.code == CMD_MASK_QUERY)
    begin
      RESP_VALID_O <= 1'b1;
      RESP_DATA_O <= {BYTE_ZERO, mask};
    end
    else if (accept && CMD_I.code == CMD_STATUS_SUMMARY_QUERY)
    begin
      RESP_VALID_O <= 1'b1;
      RESP_DATA_O <= {BYTE_ZERO, stb};
    end
    else if (st == ST_REPLY)
    begin
      RESP_VALID_O <= 1'b1;
      RESP_DATA_O <= any_fail ? REPLY_FAIL : REPLY_PASS;
    end
    else if (RESP_TAKEN_I)
      RESP_VALID_O <= 1'b0;
  end

  // ==========================================================
  // Self check sequencer
  always_comb
  begin
    step_fail = TEST_RESULT_I.fail;
    if (test_num == TEST_FIFO_IRQ)
      step_fail = step_fail || !(seen_half || FIFO_HALF_IRQ_I)
                  || !(seen_full || FIFO_FULL_IRQ_I);
    if (test_num == TEST_MEAS)
      step_fail = step_fail || !(seen_meas || MEAS_STAT_I);
  end

  always_comb
  begin
    next_st = st;
    case (st)
      ST_IDLE:
        if (accept && CMD_I.code == CMD_SELF_CHECK_QUERY)
          next_st = ST_ISSUE;
      ST_ISSUE:
        next_st = ST_WAIT;
      ST_WAIT:
        if (TEST_DONE_I)
          next_st = step_fail ? ST_LOG_TEST : ST_NEXT;
      ST_LOG_TEST:
        next_st = res.chan_valid ? ST_LOG_CHAN : (res.range_valid ? ST_LOG_RANGE : ST_NEXT);
      ST_LOG_CHAN:
        next_st = res.range_valid ? ST_LOG_RANGE : ST_NEXT;
      ST_LOG_RANGE:
        next_st = ST_NEXT;
      ST_NEXT:
        if (test_num != TEST_REST_GROUP)
          next_st = ST_ISSUE;
        else
          next_st = any_fail ? ST_ERR : ST_DEFAULTS;
      ST_ERR:
        next_st = ST_DEFAULTS;
      ST_DEFAULTS:
        next_st = ST_REPLY;
      ST_REPLY:
        next_st = ST_IDLE;
      default:
        next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      st <= ST_IDLE;
    else
      st <= next_st;
  end

  // Digital tests run in order, then one request for all other groups
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      test_num <= TEST_FIRST;
    else if (st == ST_IDLE)
      test_num <= TEST_FIRST;
    else if (st == ST_NEXT && test_num == TEST_LAST_DIGITAL)
      test_num <= TEST_REST_GROUP;
    else if (st == ST_NEXT && test_num != TEST_REST_GROUP)
      test_num <= test_num + TEST_FIRST;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      seen_half <= 1'b0;
      seen_full <= 1'b0;
      seen_meas <= 1'b0;
    end
    else if (st == ST_ISSUE)
    begin
      seen_half <= 1'b0;
      seen_full <= 1'b0;
      seen_meas <= 1'b0;
    end
    else if (st == ST_WAIT)
    begin
      seen_half <= seen_half || FIFO_HALF_IRQ_I;
      seen_full <= seen_full || FIFO_FULL_IRQ_I;
      seen_meas <= seen_meas || MEAS_STAT_I;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      res <= '0;
      fail_id <= TEST_REST_GROUP;
      any_fail <= 1'b0;
    end
    else if (st == ST_IDLE)
      any_fail <= 1'b0;
    else if (st == ST_WAIT && TEST_DONE_I)
    begin
      res <= TEST_RESULT_I;
      fail_id <= (test_num == TEST_REST_GROUP) ? TEST_RESULT_I.id : test_num;
      any_fail <= any_fail || step_fail;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      TEST_REQ_O <= 1'b0;
      TEST_NUM_O <= TEST_REST_GROUP;
      TEST_A24_O <= 1'b0;
    end
    else
    begin
      TEST_REQ_O <= st == ST_ISSUE;
      if (st == ST_ISSUE)
      begin
        TEST_NUM_O <= test_num;
        TEST_A24_O <= test_num == TEST_A24_LO || test_num == TEST_A24_HI;
      end
    end
  end

  // ==========================================================
  // Failure entries and closing actions
  always_comb
  begin
    enc_kind = ENTRY_TEST;
    enc_value = fail_id;
    case (st)
      ST_LOG_CHAN:
      begin
        enc_kind = ENTRY_CHAN;
        enc_value = {3'h0, res.chan};
      end
      ST_LOG_RANGE:
      begin
        enc_kind = ENTRY_RANGE;
        enc_value = {6'h00, res.range};
      end
      default:
      begin
        enc_kind = ENTRY_TEST;
        enc_value = fail_id;
      end
    endcase
  end

  fail_code_encoder u_enc (
    .kind_i(enc_kind),
    .value_i(enc_value),
    .code_o(enc_code),
    .ok_o(enc_ok)
  );

  // Out-of-band codes from the engine are dropped, not logged
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      FIFO_WR_O <= 1'b0;
      FIFO_DATA_O <= REPLY_PASS;
    end
    else
    begin
      FIFO_WR_O <= (st == ST_LOG_TEST || st == ST_LOG_CHAN || st == ST_LOG_RANGE) && enc_ok;
      FIFO_DATA_O <= enc_code;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      ERR_PUSH_O <= 1'b0;
      ERR_CODE_O <= REPLY_PASS;
      DEFAULTS_O <= 1'b0;
    end
    else
    begin
      ERR_PUSH_O <= st == ST_ERR;
      ERR_CODE_O <= ERR_SELF_CHECK;
      DEFAULTS_O <= st == ST_DEFAULTS;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_MASK_REPLY: assert property (accept && CMD_I.code == CMD_MASK_QUERY
    |=> RESP_VALID_O && RESP_DATA_O == {BYTE_ZERO, mask})
    else $error("mask query reply wrong");
  AST_STATUS_REPLY: assert property (accept && CMD_I.code == CMD_STATUS_SUMMARY_QUERY
    |=> RESP_DATA_O[7:0] == $past(stb))
    else $error("status query reply wrong");
  AST_QUERY_KEEPS_REQUEST: assert property (accept && CMD_I.code == CMD_STATUS_SUMMARY_QUERY
    && rqs && enabled_any |=> rqs)
    else $error("status query cleared request bit");
  AST_MAV_CLEARS: assert property (RESP_VALID_O && RESP_TAKEN_I && st != ST_REPLY
    |=> !stb[BIT_MAV])
    else $error("message bit stuck after read");
  AST_TRIGGER_GATED: assert property (TRIG_O |-> $past(TRIG_SRC_BUS_I)
    && $past(TRIG_WAITING_I) && $past(accept))
    else $error("trigger without bus source or wait");
  AST_ERROR_CODE: assert property (ERR_PUSH_O |-> ERR_CODE_O == ERR_SELF_CHECK
    ##2 RESP_DATA_O == REPLY_FAIL)
    else $error("failure not reported as -1 with error");
  AST_CHAN_BAND: assert property (FIFO_WR_O && $past(st) == ST_LOG_CHAN
    |-> FIFO_DATA_O >= CHAN_BASE && FIFO_DATA_O <= CHAN_MAX)
    else $error("channel entry out of band");
  AST_RANGE_BAND: assert property (FIFO_WR_O && $past(st) == ST_LOG_RANGE
    |-> FIFO_DATA_O >= RANGE_BASE && FIFO_DATA_O <= RANGE_MAX)
    else $error("range entry out of band");
  AST_TEST_BAND: assert property (FIFO_WR_O && $past(st) == ST_LOG_TEST
    |-> FIFO_DATA_O <= TEST_LOW_MAX || FIFO_DATA_O >= TEST_HIGH_MIN)
    else $error("test entry out of band");
  AST_DEFAULTS_THEN_REPLY: assert property (DEFAULTS_O |=> $rose(RESP_VALID_O))
    else $error("reply not right after defaults");
  AST_A24_SPACE: assert property (TEST_REQ_O && TEST_NUM_O == TEST_A24_LO
    |-> TEST_A24_O)
    else $error("pattern test not in A24 space");
  AST_IRQ_TEST: assert property (st == ST_WAIT && TEST_DONE_I && test_num == TEST_FIFO_IRQ
    && !seen_half && !FIFO_HALF_IRQ_I |-> ##2 FIFO_WR_O
    && FIFO_DATA_O == {7'h00, TEST_FIFO_IRQ})
    else $error("missing half-full interrupt not logged");
  AST_HOLD_BLOCKS: assert property (holding && OP_BUSY_I |=> !CMD_READY_O)
    else $error("command accepted during hold");

  COV_SELF_FAIL: cover property (ERR_PUSH_O);
  COV_TRIGGER: cover property (TRIG_O);
  COV_HOLD: cover property (holding && OP_BUSY_I ##1 !holding);

endmodule

/* test_engine_model.sv */
`timescale 1ns/1ps
module test_engine_model
  import common_status_pkg::*;
(
  // Requests
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [8:0] num_i,
  input wire logic skip_irq_i,
  input wire test_result_t last_i,
  // Answers
  output logic done_o,
  output test_result_t result_o,
  output logic half_o,
  output logic full_o,
  output logic meas_o
);
  // ====================
  // Engine
  // Latency varies per request so both prompt and slow answers occur
  int dly = 0;
  initial
  begin
    done_o = 1'b0;
    result_o = '1;
    {half_o, full_o, meas_o} = 3'h0;
    forever
    begin
      @(posedge clk_i);
      if (req_i === 1'b1)
      begin
        #1;
        meas_o = (num_i == TEST_MEAS);
        half_o = (num_i == TEST_FIFO_IRQ) && !skip_irq_i;
        full_o = half_o;
        repeat (dly) @(posedge clk_i);
        dly = (dly + 3) % 5;
        result_o = (num_i == TEST_REST_GROUP) ? last_i : '0;
        done_o = 1'b1;
        @(posedge clk_i);
        #1;
        done_o = 1'b0;
        // Result is junk outside the done cycle
        result_o = ~result_o;
        {half_o, full_o, meas_o} = 3'h0;
      end
    end
  end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module testbench
  import common_status_pkg::*;
;
  // ====================
  // Signals
  logic clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_ready, resp_valid, taken = 1'b0;
  cmd_req_t cmd = '0;
  logic [15:0] resp_data, fifo_data, err_code;
  logic oper = 1'b0, std = 1'b0, ques = 1'b0, srq, srq_oe, trig_src = 1'b0, trig_wait = 1'b0;
  logic [7:0] status_byte;
  logic trig, op_busy = 1'b0, test_req, test_a24, test_done, half, full, meas;
  logic [8:0] test_num;
  test_result_t result, last = '0;
  logic fifo_wr, err_push, defaults, skip_irq = 1'b0, exp_rqs;
  logic [7:0] exp_stb;
  logic [31:0] seed = 32'hc4e3;
  int n_mismatch = 0, check_count = 0, n_trig = 0, n_err = 0, n_def = 0;
  time t_take, t_free;
  logic [15:0] fifo_q[$], exp_q[$];
  logic [9:0] req_q[$];
  logic [3:0] st_o[4] = '{4'h1, 4'h7, 4'h6, 4'h4};
  logic [7:0] st_m[4] = '{8'h00, 8'h20, 8'h80, 8'h08};

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  common_command_status_unit i_dut (.CLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(cmd_valid),
    .CMD_I(cmd), .CMD_READY_O(cmd_ready), .RESP_VALID_O(resp_valid), .RESP_DATA_O(resp_data),
    .RESP_TAKEN_I(taken), .OPER_SUM_I(oper), .STD_SUM_I(std), .QUES_SUM_I(ques),
    .STATUS_BYTE_O(status_byte), .SRQ_O(srq), .SRQ_OE_O(srq_oe), .TRIG_SRC_BUS_I(trig_src),
    .TRIG_WAITING_I(trig_wait), .TRIG_O(trig), .OP_BUSY_I(op_busy), .TEST_REQ_O(test_req),
    .TEST_NUM_O(test_num), .TEST_A24_O(test_a24), .TEST_DONE_I(test_done),
    .TEST_RESULT_I(result), .FIFO_HALF_IRQ_I(half), .FIFO_FULL_IRQ_I(full),
    .MEAS_STAT_I(meas), .FIFO_WR_O(fifo_wr), .FIFO_DATA_O(fifo_data), .ERR_PUSH_O(err_push),
    .ERR_CODE_O(err_code), .DEFAULTS_O(defaults));

  test_engine_model i_engine (.clk_i(clk), .req_i(test_req), .num_i(test_num),
    .skip_irq_i(skip_irq), .last_i(last), .done_o(test_done), .result_o(result),
    .half_o(half), .full_o(full), .meas_o(meas));

  // ====================
  // Monitors
  always @(posedge clk)
  begin
    if (trig === 1'b1) n_trig++;
    if (defaults === 1'b1) n_def++;
    if (fifo_wr === 1'b1) fifo_q.push_back(fifo_data);
    if (test_req === 1'b1) req_q.push_back({test_a24, test_num});
    if (err_push === 1'b1)
    begin
      n_err++;
      `CHK(err_code, ERR_SELF_CHECK)
    end
  end

  // ====================
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Held until the edge that samples ready high
  task automatic send(input cmd_code_t c, input logic [15:0] a);
    logic r;
    int n;
    n = 0;
    cmd.code = c;
    cmd.arg = a;
    cmd_valid = 1'b1;
    do
    begin
      @(negedge clk);
      r = cmd_ready;
      @(posedge clk);
      n++;
    end while (r !== 1'b1 && n < 3000);
    t_take = $time;
    #1;
    cmd_valid = 1'b0;
    cmd.arg = ~a;
    // Let an edge pass so back-to-back calls never touch valid twice at once
    @(posedge clk);
    #1;
    if (n >= 3000) `CHK(1'b0, 1'b1)
  endtask

  task automatic query(input cmd_code_t c, input logic [15:0] e);
    logic [15:0] d;
    int n;
    n = 0;
    send(c, 16'h0000);
    while (resp_valid !== 1'b1 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    d = resp_data;
    `CHK(d, e)
    seed = lfsr(seed);
    repeat (1 + seed[1:0]) @(negedge clk);
    `CHK(status_byte[BIT_MAV], 1'b1)
    @(posedge clk);
    #1;
    taken = 1'b1;
    @(posedge clk);
    #1;
    taken = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(status_byte[BIT_MAV], 1'b0)
    @(posedge clk);
    #1;
  endtask

  task automatic run_check(input logic bad, input logic [15:0] e);
    skip_irq = bad;
    seed = lfsr(seed);
    last = '0;
    last.fail = bad;
    last.id = TEST_HIGH_MIN[8:0] + 9'(seed[6:0]);
    last.chan_valid = 1'b1;
    last.chan = seed[13:8];
    last.range_valid = 1'b1;
    last.range = (seed[17:15] > RANGE_LAST) ? RANGE_LAST : seed[17:15];
    fifo_q.delete();
    req_q.delete();
    exp_q.delete();
    n_err = 0;
    n_def = 0;
    if (bad)
    begin
      exp_q.push_back(16'd7);
      exp_q.push_back(16'(last.id));
      exp_q.push_back(16'd100 + 16'(last.chan));
      exp_q.push_back(16'd200 + 16'(last.range));
    end
    query(CMD_SELF_CHECK_QUERY, e);
    `CHK(fifo_q.size(), exp_q.size())
    foreach (exp_q[i]) `CHK(fifo_q[i], exp_q[i])
    `CHK(req_q.size(), 10)
    foreach (req_q[i]) `CHK(req_q[i], {i == 1 || i == 2, 9'((i + 1) % 10)})
    `CHK(n_err, int'(bad))
    `CHK(n_def, 1)
  endtask

  // ====================
  // Watchdog and main sequence
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    query(CMD_MASK_QUERY, 16'h0000);
    repeat (4)
    begin
      seed = lfsr(seed);
      send(CMD_SERVICE_REQUEST_MASK, seed[15:0]);
      query(CMD_MASK_QUERY, {8'h00, seed[7:0] & MASK_WRITABLE});
    end
    foreach (st_o[i])
    begin
      send(CMD_SERVICE_REQUEST_MASK, {8'h00, st_m[i]});
      {oper, std, ques} = {st_o[i][0], st_o[i][1], st_o[i][2]};
      repeat (4) @(posedge clk);
      #1;
      exp_rqs = |({oper, 1'b0, std, 1'b0, ques, 3'h0} & st_m[i]);
      exp_stb = {oper, exp_rqs, std, 1'b0, ques, 3'h0};
      repeat (2) query(CMD_STATUS_SUMMARY_QUERY, {8'h00, exp_stb});
      `CHK(status_byte, exp_stb)
      `CHK(srq_oe, exp_rqs)
      `CHK(srq, 1'b0)
    end
    for (int i = 0; i < 4; i++)
    begin
      trig_src = i[0];
      trig_wait = i[1];
      n_trig = 0;
      send(CMD_HOST_BUS_TRIGGER, 16'h0000);
      repeat (4) @(posedge clk);
      #1;
      `CHK(n_trig, (i == 3) ? 1 : 0)
    end
    op_busy = 1'b1;
    send(CMD_HOLD_UNTIL_DONE, 16'h0000);
    fork
      query(CMD_MASK_QUERY, 16'h0008);
      begin
        repeat (20) @(posedge clk);
        #1;
        op_busy = 1'b0;
        t_free = $time;
      end
    join
    `CHK(t_take > t_free, 1'b1)
    run_check(1'b0, REPLY_PASS);
    run_check(1'b1, REPLY_FAIL);
    finish_test();
  end
endmodule
